/* File: src/ebcs_pkg.sv */
// Purpose: Shared types and constants for the external bus cycle sequencer
// Assumes: One bus state per sys_clk period
// Notes:   Codes, states and carriers
package ebcs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int LINE_W = 128;

  // ----------------------------------------------------------------
  // Transfer size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZ_LONG = 2'h0;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  localparam logic [1:0] SIZ_LINE = 2'h3;

  // ----------------------------------------------------------------
  // Port size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8 = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;

  // ----------------------------------------------------------------
  // Byte counts and line step
  // ----------------------------------------------------------------
  localparam logic [4:0] BYTES_BYTE = 5'h01;
  localparam logic [4:0] BYTES_WORD = 5'h02;
  localparam logic [4:0] BYTES_LONG = 5'h04;
  localparam logic [4:0] BYTES_LINE = 5'h10;
  localparam logic [19:0] LINE_STEP = 20'h0_0001;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_PREP = 9'h002,
    ST_S0 = 9'h004,
    ST_S1 = 9'h008,
    ST_S2 = 9'h010,
    ST_S3 = 9'h020,
    ST_S4 = 9'h040,
    ST_S5 = 9'h080,
    ST_SB = 9'h100
  } ebcs_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [1:0] siz;
    logic cache_inhibit;
    logic instr_fetch;
    logic [LINE_W-1:0] wdata;
  } ebcs_req_t;

  typedef struct packed {
    logic [1:0] port_size;
    logic read_burst_enable;
    logic write_burst_enable;
    logic internal_ack;
    logic [3:0] wait_states;
  } ebcs_cs_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic addr_drive;
    logic read_not_write;
    logic xfer_in_progress_n;
    logic transfer_start_n;
    logic [1:0] xfer_width_code;
    logic chip_select_n;
    logic [3:0] byte_lane_strobe_n;
    logic output_enable_n;
    logic [DATA_W-1:0] data_out;
    logic data_drive;
  } ebcs_bus_out_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
    logic [1:0] siz;
    logic last;
  } ebcs_rd_t;

  typedef struct packed {
    ebcs_state_t st;
    logic clk_hi;
    ebcs_req_t op;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] laddr;
    logic [4:0] done;
    logic [4:0] total;
    logic line;
    logic burst;
    logic fixed;
    logic first;
    logic last;
    logic second_line;
    logic [2:0] chunk;
    logic [1:0] lane;
    logic [3:0] lanes;
    logic [1:0] siz_cur;
    logic [3:0] wait_cnt;
    ebcs_bus_out_t pins;
    logic rd_valid;
    ebcs_rd_t rd;
    logic addr_err;
  } ebcs_seq_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam ebcs_bus_out_t BUS_OUT_RESET = '{
    address: 24'h00_0000,
    addr_drive: 1'b0,
    read_not_write: 1'b1,
    xfer_in_progress_n: 1'b1,
    transfer_start_n: 1'b1,
    xfer_width_code: SIZ_LONG,
    chip_select_n: 1'b1,
    byte_lane_strobe_n: 4'hF,
    output_enable_n: 1'b1,
    data_out: 32'h0000_0000,
    data_drive: 1'b0
  };

  // Bytes per beat of a port
  function automatic logic [2:0] port_bytes(logic [1:0] port);
    case (port)
      PORT_8: port_bytes = 3'h1;
      PORT_16: port_bytes = 3'h2;
      default: port_bytes = 3'h4;
    endcase
  endfunction

endpackage

/* File: src/ebcs_two_entry_buf.sv */
// Purpose: Two-entry request buffer
// Assumes: Single clock, async reset
// Notes:   Push refused only when full
`timescale 1ns/1ns
module ebcs_two_entry_buf #(
  parameter int W = 8
) (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic in_valid, // Producer has a word
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [W-1:0] out_data // Oldest word
);

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
  } ebcs_buf_t;

  ebcs_buf_t s;
  ebcs_buf_t n;
  logic push;
  logic pop;

  assign in_ready = (s.cnt != 2'h2);
  assign out_valid = (s.cnt != 2'h0);
  assign out_data = s.e0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = s;
    if (pop) begin
      n.e0 = s.e1;
      n.cnt = n.cnt - 2'h1;
    end
    if (push) begin
      if (n.cnt == 2'h0) begin
        n.e0 = in_data;
      end else begin
        n.e1 = in_data;
      end
      n.cnt = n.cnt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule // ebcs_two_entry_buf

/* File: src/ebcs_slicer.sv */
// Purpose: Sizes one bus transfer of an operation
// Assumes: Lane mask bit 3 is data 31:24
// Notes:   Greedy largest aligned piece when not bursting
`timescale 1ns/1ns
module ebcs_slicer import ebcs_pkg::*; (
  input wire logic [1:0] lo, // Low address bits
  input wire logic [4:0] remain, // Bytes still to move
  input wire logic [1:0] port, // Port size code
  input wire logic burst, // Burst beats are port wide
  output logic [2:0] chunk, // Bytes this transfer
  output logic [1:0] siz, // Size code of the piece
  output logic [3:0] lanes, // Active byte lanes
  output logic [1:0] lane // First lane used
);

  logic [2:0] pb;

  assign pb = port_bytes(port);

  always_comb begin
    case (port)
      PORT_32: lane = lo;
      PORT_16: lane = {1'b0, lo[0]};
      default: lane = 2'h0;
    endcase
    if (burst) begin
      chunk = pb;
    end else if (lo[0] || remain < 5'h02 || pb == 3'h1) begin
      chunk = 3'h1;
    end else if (lo[1] || remain < 5'h04 || pb == 3'h2) begin
      chunk = 3'h2;
    end else begin
      chunk = 3'h4;
    end
    case (chunk)
      3'h1: begin
        siz = SIZ_BYTE;
        lanes = 4'h8 >> lane;
      end
      3'h2: begin
        siz = SIZ_WORD;
        lanes = 4'hC >> lane;
      end
      default: begin
        siz = SIZ_LONG;
        lanes = 4'hF;
      end
    endcase
  end

endmodule // ebcs_slicer

/* File: src/ebcs_sequencer.sv */
// Purpose: External bus cycle sequencer, master side
// Assumes: Slave runs on bus_clock_out
// Notes:   One bus state per sys_clk period
`timescale 1ns/1ns
// Functional notes
// - Chip select, byte strobes and output enable negate entering S5.
// - Address, direction, in-progress and size release at the end of S5.
// - Write data stops being driven at the edge ending S5.
// - Acknowledge seen at end of S1 completes a two-clock cycle.
// - Internal acknowledge never produces a fast-terminated cycle.
// - Multi-transfer operations run back to back with in-progress held low, except between the two lines of a straddling read.
// - Back-to-back choice is internal; every cycle of a run has the direction of its one operation.
// - Burst when enabled and a line or aligned operation is wider than the port.
// - Bursts run 2-1-1-1; waits come from late or programmed acknowledge.
// - Size code shows whole-transfer size, unchanged over every burst beat.
// - Separate read-burst and write-burst enables per chip select control.
// - Inhibited line: line code first, then port sized; address per ack kind.
// - Line beats start at address bits 3:2 and wrap inside the line.
// - Line read beats captured at S4, then at each acknowledged return to S4 from SB, one per clock without waits.
// - Chip select held all burst; external ack keeps address fixed.
// - Write burst data advances at the same edge that registers each beat's acknowledge.
// - Misaligned cache-inhibited operands split into aligned transfers.
// - Odd instruction fetch address raises address error, no bus access.
// - Cacheable read operand straddling a line fills both lines.
// - No acknowledge by end of first clock inserts whole-clock waits.
// - S0 drives address, direction, in-progress, size and transfer start.
module ebcs_sequencer import ebcs_pkg::*; (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic req_valid, // Operation offered
  output logic req_ready, // Buffer has room
  input wire ebcs_req_t req_data, // Operation
  input wire ebcs_cs_cfg_t chip_select_ctrl_reg, // Selected region setup
  input wire logic transfer_ack_n, // Slave acknowledge
  input wire logic [DATA_W-1:0] data_in, // Data bus level
  output logic bus_clock_out, // Bus clock
  output ebcs_bus_out_t bus, // Bus outputs and enables
  output logic rd_valid, // Read beat captured
  output ebcs_rd_t rd, // Captured read beat
  output logic addr_error // Odd instruction fetch
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ebcs_seq_t s;
  ebcs_seq_t n;
  ebcs_cs_cfg_t cfg;
  logic buf_valid;
  logic buf_ready;
  ebcs_req_t buf_data;
  logic [2:0] sl_chunk;
  logic [1:0] sl_siz;
  logic [3:0] sl_lanes;
  logic [1:0] sl_lane;
  logic [4:0] remain;
  logic [4:0] ld_bytes;
  logic ld_mis;
  logic ld_cross;
  logic ld_burst_en;
  logic ack_in;
  logic ack;
  logic enter_s0;
  logic active;
  logic strobing;
  logic [LINE_W-1:0] op_image;

  assign cfg = chip_select_ctrl_reg;
  assign remain = s.total - s.done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] size_bytes(logic [1:0] siz);
    case (siz)
      SIZ_BYTE: size_bytes = BYTES_BYTE;
      SIZ_WORD: size_bytes = BYTES_WORD;
      SIZ_LINE: size_bytes = BYTES_LINE;
      default: size_bytes = BYTES_LONG;
    endcase
  endfunction

  // Operand from the transfer start
  function automatic logic [LINE_W-1:0] operand(ebcs_req_t r, logic line,
                                                logic [1:0] first_word);
    logic [7:0] sh;
    sh = {1'b0, first_word, 5'h00};
    if (line) begin
      operand = (r.wdata << sh) | (r.wdata >> (8'h80 - sh));
    end else begin
      operand = {r.wdata[DATA_W-1:0], 96'h0};
    end
  endfunction

  // Next operand bytes on their lanes
  function automatic logic [DATA_W-1:0] bus_word(logic [LINE_W-1:0] img,
                                                 logic [4:0] done,
                                                 logic [1:0] lane);
    logic [LINE_W-1:0] t;
    t = img << {done, 3'h0};
    bus_word = t[LINE_W-1:LINE_W-DATA_W] >> {lane, 3'h0};
  endfunction

  // ----------------------------------------------------------------
  // Request buffer and transfer slicer
  // ----------------------------------------------------------------
  ebcs_two_entry_buf #(
    .W($bits(ebcs_req_t))
  ) u_req_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  ebcs_slicer u_slicer (
    .lo(s.laddr[1:0]),
    .remain(remain),
    .port(cfg.port_size),
    .burst(s.burst),
    .chunk(sl_chunk),
    .siz(sl_siz),
    .lanes(sl_lanes),
    .lane(sl_lane)
  );

  // ----------------------------------------------------------------
  // Operation classification at load
  // ----------------------------------------------------------------
  assign ld_bytes = size_bytes(buf_data.siz);
  assign ld_mis = (buf_data.siz == SIZ_WORD && buf_data.addr[0]) ||
                  (buf_data.siz == SIZ_LONG && buf_data.addr[1:0] != 2'h0);
  assign ld_cross = !buf_data.cache_inhibit && !buf_data.write && ld_mis &&
                    ({1'b0, buf_data.addr[3:0]} + ld_bytes > BYTES_LINE);
  assign ld_burst_en = buf_data.write ? cfg.write_burst_enable
                                      : cfg.read_burst_enable;
  assign op_image = operand(s.op, s.line, s.start[3:2]);
  assign ack_in = cfg.internal_ack ? (s.wait_cnt == cfg.wait_states)
                                   : !transfer_ack_n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.clk_hi = !s.clk_hi;
    n.rd_valid = 1'b0;
    n.addr_err = 1'b0;
    buf_ready = 1'b0;
    ack = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (s.clk_hi && s.second_line) begin
          n.start = {s.start[ADDR_W-1:4] + LINE_STEP, 4'h0};
          n.laddr = n.start;
          n.done = 5'h00;
          n.first = 1'b1;
          n.last = 1'b0;
          n.second_line = 1'b0;
          n.st = ST_PREP;
        end else if (s.clk_hi && buf_valid) begin
          buf_ready = 1'b1;
          if (buf_data.instr_fetch && buf_data.addr[0]) begin
            n.addr_err = 1'b1;
          end else begin
            n.op = buf_data;
            n.start = buf_data.addr;
            n.laddr = buf_data.addr;
            n.done = 5'h00;
            n.first = 1'b1;
            n.last = 1'b0;
            n.second_line = ld_cross;
            n.line = (buf_data.siz == SIZ_LINE) || ld_cross;
            if (ld_cross) begin
              n.op.siz = SIZ_LINE;
            end
            n.total = n.line ? BYTES_LINE : ld_bytes;
            n.burst = ld_burst_en && (n.total > {2'h0,
                      port_bytes(cfg.port_size)}) && (n.line || !ld_mis);
            n.fixed = (n.burst || n.line) && !cfg.internal_ack;
            n.st = ST_PREP;
          end
        end
      end
      ST_PREP: n.st = ST_S0;
      ST_S0: n.st = ST_S1;
      ST_S1: begin
        if (!cfg.internal_ack && !transfer_ack_n) begin
          ack = 1'b1;
          n.st = ST_S4;
        end else begin
          n.st = ST_S2;
        end
      end
      ST_S2: n.st = ST_S3;
      ST_S3: begin
        if (ack_in) begin
          ack = 1'b1;
          n.st = ST_S4;
        end else begin
          n.wait_cnt = s.wait_cnt + 4'h1;
          n.st = ST_S2;
        end
      end
      ST_S4: n.st = (s.burst && !s.last) ? ST_SB : ST_S5;
      ST_SB: begin
        if (ack_in) begin
          ack = 1'b1;
        end else begin
          n.wait_cnt = s.wait_cnt + 4'h1;
        end
        n.st = ST_S4;
      end
      ST_S5: n.st = s.last ? ST_IDLE : ST_S0;
      default: n.st = ST_IDLE;
    endcase

    // Beat acknowledged: capture, count, step
    if (ack) begin
      n.wait_cnt = 4'h0;
      if (!s.op.write) begin
        n.rd_valid = 1'b1;
        n.rd.data = data_in;
        n.rd.addr = s.laddr;
        n.rd.siz = s.siz_cur;
      end
      n.done = s.done + {2'h0, s.chunk};
      if (s.line) begin
        n.laddr = {s.laddr[ADDR_W-1:4],
                   s.laddr[3:0] + {1'b0, s.chunk}};
      end else begin
        n.laddr = s.laddr + {21'h00_0000, s.chunk};
      end
      n.last = (n.done >= s.total);
      n.rd.last = n.last && !s.second_line;
      if (s.burst && !n.last) begin
        n.pins.data_out = bus_word(op_image, n.done, s.lane);
        if (!s.fixed) begin
          n.pins.address = n.laddr;
        end
      end
    end

    // New transfer: latch its shape
    enter_s0 = (n.st == ST_S0) && (s.st != ST_S0);
    if (enter_s0) begin
      n.chunk = sl_chunk;
      n.lane = sl_lane;
      n.lanes = sl_lanes;
      n.wait_cnt = 4'h0;
      n.first = 1'b0;
      if (s.burst) begin
        n.siz_cur = s.op.siz;
      end else if (s.line && s.first) begin
        n.siz_cur = SIZ_LINE;
      end else begin
        n.siz_cur = sl_siz;
      end
      n.pins.address = s.fixed ? s.start : s.laddr;
      n.pins.data_out = bus_word(op_image, s.done, sl_lane);
    end

    // Pin levels follow the state being entered
    active = (n.st != ST_IDLE) && (n.st != ST_PREP);
    strobing = (n.st == ST_S1) || (n.st == ST_S2) || (n.st == ST_S3) ||
               (n.st == ST_S4) || (n.st == ST_SB);
    n.pins.addr_drive = active;
    n.pins.read_not_write = !s.op.write || !active;
    n.pins.xfer_in_progress_n = !active;
    n.pins.transfer_start_n = (n.st != ST_S0);
    n.pins.xfer_width_code = active ? n.siz_cur : SIZ_LONG;
    n.pins.chip_select_n = !strobing;
    n.pins.byte_lane_strobe_n = strobing ? ~n.lanes : 4'hF;
    n.pins.output_enable_n = !(strobing && !s.op.write);
    n.pins.data_drive = s.op.write && (strobing || n.st == ST_S5);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.pins <= BUS_OUT_RESET;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_clock_out = s.clk_hi;
  assign bus = s.pins;
  assign rd_valid = s.rd_valid;
  assign rd = s.rd;
  assign addr_error = s.addr_err;

endmodule // ebcs_sequencer

/* File: tb/ebcs_slave_model.sv */
// Purpose: Bus slave model
// Assumes: Outputs change 1 ns after each rising edge
// Notes:   Acks every odd state from the chosen one
`timescale 1ns/1ns
module ebcs_slave_model import ebcs_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic bus_clock_out, // Bus clock
  input wire ebcs_bus_out_t bus, // Master outputs
  input wire logic internal_ack, // Region terminates itself
  input wire logic fast, // Ack in the first odd state
  input wire logic [3:0] waits, // Extra clocks before ack
  output logic transfer_ack_n, // Ack to master
  output logic [DATA_W-1:0] data_in // Data bus level
);
  int k;
  logic [7:0] beat;
  logic ack;
  initial begin
    transfer_ack_n = 1'b1;
    data_in = 32'h0000_0000;
  end
  always @(posedge sys_clk) begin
    #1;
    if (reset || bus.chip_select_n) begin
      k = 0;
      beat = 8'h00;
    end else if (!bus_clock_out) begin
      k = k + 1;
    end
    ack = !internal_ack && !bus.chip_select_n && !bus_clock_out &&
      k >= (fast ? 1 : 2 + waits);
    transfer_ack_n <= !ack;
    // Released bus shows a changing pattern
    if (ack && bus.read_not_write) begin
      data_in <= {8'hD0 + beat, bus.address};
    end else begin
      data_in <= ~data_in;
    end
    if (ack) begin
      beat = beat + 8'h01;
    end
  end
endmodule // ebcs_slave_model

/* File: tb/ebcs_seq_chk_assertions.sv */
// Purpose: Sequencer port checks
// Assumes: One clock domain, reset active high
// Notes:   Bound at the foot of this file
`timescale 1ns/1ns
module ebcs_seq_chk import ebcs_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Async reset
  input wire ebcs_cs_cfg_t chip_select_ctrl_reg, // Region setup
  input wire logic transfer_ack_n, // Slave ack
  input wire logic bus_clock_out, // Bus clock
  input wire ebcs_bus_out_t bus, // Bus outputs
  input wire logic rd_valid, // Read beat
  input wire logic addr_error // Fetch error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_s5;
    $rose(bus.chip_select_n) && !bus_clock_out;
  endsequence
  sequence s_start;
    !bus.transfer_start_n;
  endsequence
  property p_phase;
    1 |=> bus_clock_out != $past(bus_clock_out);
  endproperty
  property p_start;
    s_start |-> (bus_clock_out && !bus.xfer_in_progress_n && bus.addr_drive)
      ##1 (bus.transfer_start_n && !bus.chip_select_n);
  endproperty
  property p_s5_neg;
    s_s5 |-> &bus.byte_lane_strobe_n && bus.output_enable_n;
  endproperty
  property p_release;
    s_s5 |=> ((bus.xfer_in_progress_n && !bus.addr_drive) ||
      !bus.transfer_start_n) && !bus.data_drive;
  endproperty
  property p_ext_capture;
    !chip_select_ctrl_reg.internal_ack && !transfer_ack_n && !bus_clock_out
      && !bus.chip_select_n && bus.read_not_write |=> rd_valid;
  endproperty
  property p_cause;
    rd_valid && !chip_select_ctrl_reg.internal_ack
      |-> !$past(transfer_ack_n) && !$past(bus_clock_out);
  endproperty
  property p_no_fast;
    s_start and chip_select_ctrl_reg.internal_ack
      |=> !bus.chip_select_n [*4];
  endproperty
  property p_tip_rise;
    $rose(bus.xfer_in_progress_n)
      |-> $past(bus.chip_select_n) && !$past(bus_clock_out);
  endproperty
  property p_size_hold;
    !bus.chip_select_n && !$past(bus.chip_select_n)
      |-> $stable(bus.xfer_width_code);
  endproperty
  property p_addr_fixed;
    !chip_select_ctrl_reg.internal_ack && !bus.chip_select_n &&
      !$past(bus.chip_select_n) |-> $stable(bus.address);
  endproperty
  property p_addr_err;
    addr_error |-> bus.xfer_in_progress_n && !rd_valid;
  endproperty
  a_phase: assert property (p_phase) else $error("bus clock stuck");
  a_start: assert property (p_start) else $error("bad start");
  a_s5_neg: assert property (p_s5_neg) else $error("strobes held");
  a_release: assert property (p_release) else $error("no release");
  a_ext_capture: assert property (p_ext_capture) else $error("missed");
  a_cause: assert property (p_cause) else $error("capture no ack");
  a_no_fast: assert property (p_no_fast) else $error("fast internal");
  a_tip_rise: assert property (p_tip_rise) else $error("early idle");
  a_size_hold: assert property (p_size_hold) else $error("size moved");
  a_addr_fixed: assert property (p_addr_fixed) else $error("addr moved");
  a_addr_err: assert property (p_addr_err) else $error("bus used");
endmodule // ebcs_seq_chk
bind ebcs_sequencer ebcs_seq_chk i_chk (.sys_clk(sys_clk), .reset(reset),
  .chip_select_ctrl_reg(chip_select_ctrl_reg),
  .transfer_ack_n(transfer_ack_n), .bus_clock_out(bus_clock_out),
  .bus(bus), .rd_valid(rd_valid), .addr_error(addr_error));

/* File: tb/test_external_bus_cycle_sequencer.sv */
// Purpose: Bench of the bus cycle sequencer
// Assumes: Slave model on the bus side
// Notes:   Monitor logs beats per operation
`timescale 1ns/1ns
module test_external_bus_cycle_sequencer;
  import ebcs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  ebcs_req_t req_data = '0;
  ebcs_cs_cfg_t cfg = '0;
  logic fast = 1'b0;
  logic [3:0] waits = 4'h0;
  logic req_ready, transfer_ack_n, bus_clock_out, rd_valid, addr_error;
  logic tip_q = 1'b1;
  logic [DATA_W-1:0] data_in;
  ebcs_bus_out_t bus;
  ebcs_rd_t rd;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_ts, n_tip, n_err, t, pushes;
  ebcs_rd_t got[$];
  int stamp[$];
  always #20 sys_clk = ~sys_clk;
  ebcs_sequencer i_dut (.sys_clk(sys_clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
    .chip_select_ctrl_reg(cfg), .transfer_ack_n(transfer_ack_n),
    .data_in(data_in), .bus_clock_out(bus_clock_out), .bus(bus),
    .rd_valid(rd_valid), .rd(rd), .addr_error(addr_error));
  ebcs_slave_model i_slave (.sys_clk(sys_clk), .reset(reset),
    .bus_clock_out(bus_clock_out), .bus(bus),
    .internal_ack(cfg.internal_ack), .fast(fast), .waits(waits),
    .transfer_ack_n(transfer_ack_n), .data_in(data_in));
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      got.push_back(rd);
      stamp.push_back(cyc);
    end
    if (bus.transfer_start_n === 1'b0) n_ts++;
    if (bus.xfer_in_progress_n === 1'b1 && tip_q === 1'b0) n_tip++;
    if (addr_error === 1'b1) n_err++;
    tip_q = bus.xfer_in_progress_n;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp,
    input logic [31:0] act);
    n_compared++;
    if (act !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic ebcs_req_t mk(input logic [23:0] a, input logic w,
    input logic [1:0] s, input logic ifetch);
    mk = '{a, w, s, 1'b1, ifetch, {4{32'h1234_5678}}};
  endfunction
  task automatic run(input ebcs_req_t r, input logic [1:0] port,
    input logic [1:0] b, input logic ia);
    got.delete();
    stamp.delete();
    n_ts = 0;
    n_tip = 0;
    n_err = 0;
    cfg <= '{port, b[1], b[0], ia, waits};
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_data <= r;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    t = 0;
    while ((t < 8 || bus.xfer_in_progress_n !== 1'b1) && t < 400) begin
      @(posedge sys_clk);
      t++;
    end
    cmp("op completion", 1, t < 400);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic chk(input int i, input logic [23:0] a, input logic [1:0] s);
    cmp("rd addr", {8'h00, a}, {8'h00, got[i].addr});
    cmp("rd size code", {30'h0, s}, {30'h0, got[i].siz});
    cmp("rd last", {31'h0, i == got.size() - 1}, {31'h0, got[i].last});
  endtask
  task automatic spacing();
    for (int j = 1; j < stamp.size(); j++) begin
      cmp("beat spacing", 2, stamp[j] - stamp[j - 1]);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      fast <= (m == 1);
      waits <= (m > 1) ? 4'h2 : 4'h0;
      run(mk(24'h00_0100, 1'b0, SIZ_LONG, 1'b0), PORT_32, 2'b00, m == 3);
      cmp("beats", 1, got.size());
      chk(0, 24'h00_0100, SIZ_LONG);
      if (m < 3) cmp("rd data", 32'hD000_0100, got[0].data);
    end
    fast <= 1'b0;
    waits <= 4'h0;
    run(mk(24'h00_0100, 1'b1, SIZ_LONG, 1'b0), PORT_32, 2'b00, 1'b0);
    cmp("write starts", 1, n_ts);
    for (int w = 0; w < 2; w++) begin
      run(mk(24'h00_0200, !w[0], SIZ_LONG, 1'b0), PORT_16, 2'b00, 1'b0);
      cmp("transfers", 2, n_ts);
      cmp("idle gaps", 1, n_tip);
    end
    chk(0, 24'h00_0200, SIZ_WORD);
    run(mk(24'h00_0300, 1'b0, SIZ_LONG, 1'b0), PORT_8, 2'b10, 1'b0);
    cmp("burst starts", 1, n_ts);
    for (int j = 0; j < 4; j++) chk(j, 24'h00_0300 + 24'(j), SIZ_LONG);
    spacing();
    for (int k = 0; k < 4; k++) begin
      run(mk(24'h00_0400 + 24'(4 * k), 1'b0, SIZ_LINE, 1'b0), PORT_32, 2'b10,
        1'b0);
      cmp("line beats", 4, got.size());
      for (int j = 0; j < 4; j++) begin
        chk(j, 24'h00_0400 + 24'(((k + j) % 4) * 4), SIZ_LINE);
      end
      spacing();
    end
    run(mk(24'h00_050C, 1'b0, SIZ_LINE, 1'b0), PORT_32, 2'b01, 1'b0);
    cmp("inhibited starts", 4, n_ts);
    chk(0, 24'h00_050C, SIZ_LINE);
    for (int j = 1; j < 4; j++) begin
      chk(j, 24'h00_0500 + 24'(((3 + j) % 4) * 4), SIZ_LONG);
    end
    run(mk(24'h00_0601, 1'b0, SIZ_LONG, 1'b0), PORT_32, 2'b00, 1'b0);
    cmp("split count", 3, got.size());
    chk(0, 24'h00_0601, SIZ_BYTE);
    chk(1, 24'h00_0602, SIZ_WORD);
    chk(2, 24'h00_0604, SIZ_BYTE);
    for (int w = 0; w < 2; w++) begin
      run(mk(24'h00_0400, 1'b1, SIZ_LINE, 1'b0), PORT_32, {1'b1, w[0]}, 1'b0);
      cmp("line write starts", w ? 1 : 4, n_ts);
    end
    run(mk(24'h00_0701, 1'b0, SIZ_WORD, 1'b1), PORT_32, 2'b00, 1'b0);
    cmp("fetch error", 1, n_err);
    cmp("fetch starts", 0, n_ts);
    waits <= 4'h3;
    cfg <= '{PORT_32, 1'b0, 1'b0, 1'b0, 4'h3};
    got.delete();
    t = 0;
    pushes = 0;
    req_data <= mk(24'h00_0800, 1'b0, SIZ_LONG, 1'b0);
    req_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req_valid === 1'b1 && req_ready === 1'b1) pushes++;
      t++;
    end while (req_ready !== 1'b0 && t < 40);
    req_valid <= 1'b0;
    cmp("buffer refused", 1, t < 40);
    t = 0;
    while (got.size() < pushes && t < 600) begin
      @(posedge sys_clk);
      t++;
    end
    cmp("ops drained", pushes, got.size());
    cmp("ready after drain", 1, req_ready);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    final_report();
  end
endmodule // test_external_bus_cycle_sequencer
